// ==== rtl/cmd_decoder_pkg.sv ====
// Package for the command byte decoder: field positions, opcodes, register map, types.
// Assumes one 10 MHz clock domain and an Avalon-MM slave with 32-bit data.
package cmd_decoder_pkg;

  // Command byte fields
  localparam int unsigned OP_LSB      = 0;  // Operation selector low bit
  localparam int unsigned OP_MSB      = 4;  // Operation selector high bit
  localparam int unsigned FIXED_BIT   = 5;  // One selects fixed point
  localparam int unsigned SHORT_BIT   = 6;  // One selects 16-bit fixed point
  localparam int unsigned SVC_BIT     = 7;  // Post-execution service request
  localparam logic [7:0]  SVC_MASK    = 8'h80;
  localparam logic [7:0]  CODE_MASK   = 8'h7f;

  // Command codes, with the service bit clear
  localparam logic [7:0] IDLE_COMMAND                 = 8'h00;
  localparam logic [7:0] SQUARE_ROOT_OP               = 8'h01;
  localparam logic [7:0] CIRCULAR_FUNCTION_OP         = 8'h02;
  localparam logic [7:0] COSINE_OP                    = 8'h03;
  localparam logic [7:0] SLOPE_FUNCTION_OP            = 8'h04;
  localparam logic [7:0] ARC_FUNCTION_OP              = 8'h05;
  localparam logic [7:0] ARC_COFUNCTION_OP            = 8'h06;
  localparam logic [7:0] ARC_SLOPE_OP                 = 8'h07;
  localparam logic [7:0] COMMON_LOG_OP                = 8'h08;
  localparam logic [7:0] NATURAL_EXPONENT_INVERSE_OP  = 8'h09;
  localparam logic [7:0] E_POWER_OP                   = 8'h0a;
  localparam logic [7:0] B_RAISED_TO_A_OP             = 8'h0b;
  localparam logic [7:0] FLOAT_ADD_OP                 = 8'h10;
  localparam logic [7:0] FLOAT_SUBTRACT_OP            = 8'h11;
  localparam logic [7:0] FLOAT_MULTIPLY_OP            = 8'h12;
  localparam logic [7:0] FLOAT_DIVIDE_OP              = 8'h13;
  localparam logic [7:0] FLOAT_NEGATE_OP              = 8'h15;
  localparam logic [7:0] FLOAT_DUP_TOP_OP             = 8'h17;
  localparam logic [7:0] FLOAT_STACK_ROTATE_OP        = 8'h18;
  localparam logic [7:0] FLOAT_SWAP_OP                = 8'h19;
  localparam logic [7:0] FLOAT_PUSH_PI_OP             = 8'h1a;
  localparam logic [7:0] LONG_INT_TO_FLOAT_OP         = 8'h1c;
  localparam logic [7:0] SHORT_INT_TO_FLOAT_OP        = 8'h1d;
  localparam logic [7:0] FLOAT_TO_LONG_INT_OP         = 8'h1e;
  localparam logic [7:0] FLOAT_TO_SHORT_INT_OP        = 8'h1f;
  localparam logic [7:0] LONG_ADD_OP                  = 8'h2c;
  localparam logic [7:0] LONG_SUBTRACT_OP             = 8'h2d;
  localparam logic [7:0] LONG_MULTIPLY_LOW_OP         = 8'h2e;
  localparam logic [7:0] LONG_DIVIDE_OP               = 8'h2f;
  localparam logic [7:0] LONG_NEGATE_OP               = 8'h34;
  localparam logic [7:0] LONG_MULTIPLY_HIGH_OP        = 8'h36;
  localparam logic [7:0] LONG_DUP_TOP_OP              = 8'h37;
  localparam logic [7:0] LONG_STACK_ROTATE_OP         = 8'h38;
  localparam logic [7:0] LONG_SWAP_OP                 = 8'h39;
  localparam logic [7:0] SHORT_ADD_OP                 = 8'h6c;
  localparam logic [7:0] SHORT_SUBTRACT_OP            = 8'h6d;
  localparam logic [7:0] SHORT_MULTIPLY_LOW_OP        = 8'h6e;
  localparam logic [7:0] SHORT_DIVIDE_OP              = 8'h6f;
  localparam logic [7:0] SHORT_NEGATE_OP              = 8'h74;
  localparam logic [7:0] SHORT_MULTIPLY_HIGH_OP       = 8'h76;
  localparam logic [7:0] SHORT_DUP_TOP_OP             = 8'h77;
  localparam logic [7:0] SHORT_STACK_ROTATE_OP        = 8'h78;
  localparam logic [7:0] SHORT_SWAP_OP                = 8'h79;

  // Stack arrangement after execution, one code per table pattern
  typedef enum logic [3:0] {
    ARR_KEEP,      // A B C D unchanged in place (or R B C D)
    ARR_RBUU,      // Result, B kept, C D undefined
    ARR_RUUU,      // Result only
    ARR_RBCU,      // Result, B C kept
    ARR_RCDU,      // Binary op, B consumed, bottom undefined
    ARR_RCDA,      // Binary op, A wraps to bottom
    ARR_RCUU,      // Power function
    ARR_ROTATE,    // B C D A
    ARR_DUP,       // A A B C
    ARR_SWAP,      // B A C D
    ARR_PUSH_RES,  // R A B C
    ARR_NONE       // Illegal or unknown code
  } stack_arr_t;

  // Flag update mask order: sign, zero, overflow, carry, error
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_Z = 3;
  localparam int unsigned FLG_O = 2;
  localparam int unsigned FLG_C = 1;
  localparam int unsigned FLG_E = 0;

  // Operand format
  typedef enum logic [1:0] { FMT_FLOAT, FMT_LONG, FMT_SHORT, FMT_ILLEGAL } fmt_t;

  // Decoded command carried to the execution side
  typedef struct packed {
    logic [4:0] op;        // Operation selector
    fmt_t       fmt;       // Operand format and precision
    logic       svc;       // Service request wanted
    logic       legal;     // Code found in the table
    stack_arr_t arr;       // Stack arrangement after execution
    logic [4:0] flags;     // Flags that this command updates
    logic       word16;    // Stack handled as eight 16-bit words
  } decoded_cmd_t;

  // Register map (word addresses, one per 32-bit register)
  localparam logic [3:0] ADDR_CMD    = 4'h0;  // W: command byte, R: latched byte
  localparam logic [3:0] ADDR_STATUS = 4'h1;  // R: busy, service request, decode
  localparam logic [3:0] ADDR_DONE   = 4'h2;  // W: execution complete strobe
  localparam logic [3:0] ADDR_ACK    = 4'h3;  // W: service acknowledge strobe
  localparam logic [31:0] UNMAPPED_READ = 32'hdead_beef;

  // Status word layout
  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_SVC   = 1;
  localparam int unsigned ST_LEGAL = 2;
  localparam int unsigned ST_FMT   = 4;   // Two bits
  localparam int unsigned ST_ARR   = 8;   // Four bits
  localparam int unsigned ST_FLG   = 16;  // Five bits

endpackage

// ==== rtl/cmd_decoder.sv ====
// Command byte decoder: latches one command, decodes it, tracks busy and service request.
// Assumes an Avalon-MM master on the same clock and an execution unit driving done.
`timescale 1ns/1ps
module cmd_decoder
  import cmd_decoder_pkg::*;
(
  input  wire logic         clk_sys_in,               // 10 MHz system clock
  input  wire logic         arst_n_in,                // Async reset, active low
  input  wire logic [3:0]   avs_address_in,           // Word address
  input  wire logic         avs_read_in,              // Read request
  input  wire logic         avs_write_in,             // Write request
  input  wire logic [31:0]  avs_writedata_in,         // Write data
  input  wire logic [3:0]   avs_byteenable_in,        // Byte lanes
  output logic [31:0]       avs_readdata_out,         // Read data
  output logic              avs_waitrequest_out,      // Stall
  input  wire logic         post_service_ack_n_in,    // Pin, active low
  output logic              post_service_request_out, // Service request pin
  output logic              busy_out,                 // Command executing
  output decoded_cmd_t      decoded_out               // Decode held while busy
);

  // Bus handshake: one wait cycle, then accept
  logic        ack_r;            // Answer phase flag
  logic [31:0] rdata_r;          // Registered read data
  logic [7:0]  cmd_r;            // Latched command byte
  logic        busy_r;           // Executing
  logic        svc_r;            // Service request level
  logic        ack_s1_r;         // Ack synchroniser stage one
  logic        ack_s2_r;         // Ack synchroniser stage two
  decoded_cmd_t dec_r;           // Held decode

  // Request decode
  wire logic req_w      = avs_read_in | avs_write_in;
  wire logic take_w     = req_w & ack_r;
  wire logic lane0_w    = avs_byteenable_in[0];
  wire logic wr_cmd_w   = take_w & avs_write_in & lane0_w & (avs_address_in == ADDR_CMD);
  wire logic wr_done_w  = take_w & avs_write_in & lane0_w & (avs_address_in == ADDR_DONE);
  wire logic wr_ack_w   = take_w & avs_write_in & lane0_w & (avs_address_in == ADDR_ACK);
  // A new command is taken only when idle; a command during execution is dropped
  wire logic accept_w   = wr_cmd_w & ~busy_r;
  wire logic finish_w   = wr_done_w & busy_r;
  wire logic ack_lvl_w  = ~ack_s2_r;

  wire logic [7:0] byte_w = avs_writedata_in[7:0];
  decoded_cmd_t dec_w;

  // Combinational decode of the incoming byte
  always_comb
  begin
    dec_w        = '0;
    dec_w.op     = byte_w[OP_MSB:OP_LSB];
    if (!byte_w[FIXED_BIT])
      dec_w.fmt  = byte_w[SHORT_BIT] ? FMT_ILLEGAL : FMT_FLOAT;  // undefined case
    else
      dec_w.fmt  = byte_w[SHORT_BIT] ? FMT_SHORT : FMT_LONG;
    dec_w.svc    = byte_w[SVC_BIT];
    dec_w.word16 = byte_w[FIXED_BIT] & byte_w[SHORT_BIT];
    dec_w.legal  = 1'b1;
    dec_w.arr    = ARR_NONE;
    dec_w.flags  = 5'h00;
    // codes compared with the service bit masked off
    // arrangements name entries A to D, A on top
    unique case (byte_w & CODE_MASK)
      SQUARE_ROOT_OP:             begin dec_w.arr = ARR_RBCU; dec_w.flags = 5'b11001; end
      CIRCULAR_FUNCTION_OP,
      COSINE_OP:                  begin dec_w.arr = ARR_RBUU; dec_w.flags = 5'b11000; end
      SLOPE_FUNCTION_OP:          begin dec_w.arr = ARR_RBUU; dec_w.flags = 5'b11001; end
      ARC_FUNCTION_OP,
      ARC_COFUNCTION_OP:          begin dec_w.arr = ARR_RUUU; dec_w.flags = 5'b11001; end
      ARC_SLOPE_OP:               begin dec_w.arr = ARR_RBUU; dec_w.flags = 5'b11000; end
      COMMON_LOG_OP,
      NATURAL_EXPONENT_INVERSE_OP,
      E_POWER_OP:                 begin dec_w.arr = ARR_RBUU; dec_w.flags = 5'b11001; end
      B_RAISED_TO_A_OP:           begin dec_w.arr = ARR_RCUU; dec_w.flags = 5'b11001; end
      FLOAT_ADD_OP, FLOAT_SUBTRACT_OP,
      FLOAT_MULTIPLY_OP,
      FLOAT_DIVIDE_OP:            begin dec_w.arr = ARR_RCDU; dec_w.flags = 5'b11001; end
      FLOAT_NEGATE_OP:            begin dec_w.arr = ARR_KEEP; dec_w.flags = 5'b11000; end
      FLOAT_DUP_TOP_OP,
      LONG_DUP_TOP_OP:            begin dec_w.arr = ARR_DUP; dec_w.flags = 5'b11000; end
      FLOAT_STACK_ROTATE_OP,
      LONG_STACK_ROTATE_OP:       begin dec_w.arr = ARR_ROTATE; dec_w.flags = 5'b11000; end
      FLOAT_SWAP_OP,
      LONG_SWAP_OP:               begin dec_w.arr = ARR_SWAP; dec_w.flags = 5'b11000; end
      FLOAT_PUSH_PI_OP:           begin dec_w.arr = ARR_PUSH_RES; dec_w.flags = 5'b11000; end
      LONG_INT_TO_FLOAT_OP,
      SHORT_INT_TO_FLOAT_OP:      begin dec_w.arr = ARR_RBCU; dec_w.flags = 5'b11000; end
      FLOAT_TO_LONG_INT_OP,
      FLOAT_TO_SHORT_INT_OP:      begin dec_w.arr = ARR_RBCU; dec_w.flags = 5'b11100; end
      LONG_ADD_OP:                begin dec_w.arr = ARR_RCDA; dec_w.flags = 5'b11011; end
      LONG_SUBTRACT_OP:           begin dec_w.arr = ARR_RCDA; dec_w.flags = 5'b11110; end
      LONG_MULTIPLY_LOW_OP,
      LONG_MULTIPLY_HIGH_OP:      begin dec_w.arr = ARR_RCDU; dec_w.flags = 5'b11100; end
      LONG_DIVIDE_OP:             begin dec_w.arr = ARR_RCDU; dec_w.flags = 5'b11001; end
      LONG_NEGATE_OP:             begin dec_w.arr = ARR_KEEP; dec_w.flags = 5'b11100; end
      // 16-bit arithmetic on top two words, then 16-bit stack codes
      SHORT_ADD_OP:               begin dec_w.arr = ARR_RCDA; dec_w.flags = 5'b11011; end
      SHORT_SUBTRACT_OP:          begin dec_w.arr = ARR_RCDA; dec_w.flags = 5'b11011; end
      SHORT_MULTIPLY_LOW_OP,
      SHORT_MULTIPLY_HIGH_OP,
      SHORT_DIVIDE_OP:            begin dec_w.arr = ARR_RCDU; dec_w.flags = 5'b11001; end
      SHORT_NEGATE_OP:            begin dec_w.arr = ARR_KEEP; dec_w.flags = 5'b11100; end
      SHORT_DUP_TOP_OP:           begin dec_w.arr = ARR_DUP; dec_w.flags = 5'b11000; end
      SHORT_STACK_ROTATE_OP:      begin dec_w.arr = ARR_ROTATE; dec_w.flags = 5'b11000; end
      SHORT_SWAP_OP:              begin dec_w.arr = ARR_SWAP; dec_w.flags = 5'b11000; end
      // Idle leaves stack and flags alone
      IDLE_COMMAND:               begin dec_w.arr = ARR_KEEP; dec_w.flags = 5'b00000; end
      // Undefined codes: no flag written, marked illegal
      default:                    begin dec_w.legal = 1'b0; end
    endcase
  end

  // Bus answer: waitrequest high on the first request cycle only
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ack_r <= 1'b0;
    else
      ack_r <= req_w & ~ack_r;
  end
  assign avs_waitrequest_out = req_w & ~ack_r;

  // Read mux, unmapped reads give a marker value
  wire logic [31:0] status_w = {11'h000, dec_r.flags, 4'h0, 4'(dec_r.arr),
                                2'h0, 2'(dec_r.fmt), 1'b0, dec_r.legal, svc_r, busy_r};
  wire logic [31:0] rmux_w   = (avs_address_in == ADDR_CMD)    ? {24'h000000, cmd_r} :
                               (avs_address_in == ADDR_STATUS) ? status_w :
                               (avs_address_in == ADDR_DONE)   ? 32'h0000_0000 :
                               (avs_address_in == ADDR_ACK)    ? 32'h0000_0000 :
                               UNMAPPED_READ;

  // Read data registered in the wait cycle, valid at the accept edge
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rdata_r <= 32'h0000_0000;
    else if (avs_read_in & ~ack_r)
      rdata_r <= rmux_w;
  end
  assign avs_readdata_out = rdata_r;

  // latch byte and decode, hold until the next accepted command
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cmd_r <= 8'h00;
      dec_r <= '0;
    end
    else if (accept_w)
    begin
      cmd_r <= byte_w;
      dec_r <= dec_w;
    end
  end

  // Busy from accepted command until done strobe
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      busy_r <= 1'b0;
    else if (accept_w)
      busy_r <= 1'b1;
    else if (finish_w)
      busy_r <= 1'b0;
  end

  // Ack pin synchroniser, only stage two is read
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ack_s1_r <= 1'b1;
      ack_s2_r <= 1'b1;
    end
    else
    begin
      ack_s1_r <= post_service_ack_n_in;
      ack_s2_r <= ack_s1_r;
    end
  end

  // Service request; completion with bit 7 set wins over a same-cycle ack
  // set on completion, clear by ack or clear-bit completion
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      svc_r <= 1'b0;
    else if (finish_w)
      svc_r <= dec_r.svc;
    else if (ack_lvl_w || wr_ack_w)
      svc_r <= 1'b0;
  end

  assign post_service_request_out = svc_r;
  assign busy_out                 = busy_r;
  assign decoded_out              = dec_r;

  // Assertions
  // request rises one edge after a bit-7 completion
  property p_svc_set;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (finish_w && dec_r.svc) |=> post_service_request_out;
  endproperty
  a_svc_set: assert property (p_svc_set) else $error("service request not raised");

  property p_svc_clear;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (finish_w && !dec_r.svc) |=> !post_service_request_out;
  endproperty
  a_svc_clear: assert property (p_svc_clear) else $error("service request not low");

  property p_svc_rise;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    $rose(post_service_request_out) |-> $past(finish_w);
  endproperty
  a_svc_rise: assert property (p_svc_rise) else $error("service request rose alone");

  property p_hold;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (busy_r && !$past(accept_w)) |-> $stable(decoded_out);
  endproperty
  a_hold: assert property (p_hold) else $error("decode changed while busy");

  property p_fmt;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    accept_w && byte_w[FIXED_BIT] |=> (decoded_out.fmt != FMT_FLOAT);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format decode wrong");

  property p_op;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    accept_w |=> (decoded_out.op == $past(avs_writedata_in[4:0]));
  endproperty
  a_op: assert property (p_op) else $error("operation selector wrong");

  // short precision only with both bits
  property p_short;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    accept_w |=> (decoded_out.word16 == ($past(byte_w[5]) && $past(byte_w[6])));
  endproperty
  a_short: assert property (p_short) else $error("precision decode wrong");

  property p_idle;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    accept_w && ((byte_w & CODE_MASK) == IDLE_COMMAND) |=> (decoded_out.flags == 5'h00);
  endproperty
  a_idle: assert property (p_idle) else $error("idle wrote flags");

  // Waitrequest lasts one cycle
  property p_wait;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest too long");

  c_cmd: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) accept_w);
  c_svc: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $rose(post_service_request_out));
  c_ack: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    svc_r && ack_lvl_w);

endmodule // cmd_decoder

// ==== testbench/svc_ack_model.sv ====
// Host-side model of the service acknowledge pin.
// Assumes the decoder's request pin and the same clock and reset as the decoder.
`timescale 1ns/1ps
module svc_ack_model
(
  input  wire logic       clk_sys_in,  // System clock
  input  wire logic       arst_n_in,   // Async reset, active low
  input  wire logic       request_in,  // Service request pin
  input  wire logic       enable_in,   // Host may answer
  input  wire logic [3:0] delay_in,    // Cycles before answering
  output logic            ack_n_out    // Acknowledge pin, active low
);
  logic [3:0] wait_r;  // Cycles waited so far

  // Answer after the delay, hold low until the request drops
  // low level clears
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wait_r    <= 4'h0;
      ack_n_out <= 1'h1;
    end
    else if (!(enable_in && request_in))
    begin
      // Back high at once, or the next request would be cleared early
      wait_r    <= 4'h0;
      ack_n_out <= 1'h1;
    end
    else if (wait_r == delay_in)
      ack_n_out <= 1'h0;
    else
      wait_r <= wait_r + 4'h1;
  end
endmodule // svc_ack_model

// ==== testbench/cmd_decoder_tb_top.sv ====
// Testbench for the command byte decoder: code table, refusals, service request.
// Assumes the package, the decoder and the acknowledge model are compiled first.
`timescale 1ns/1ps
module cmd_decoder_tb_top
  import cmd_decoder_pkg::*;
;
  typedef struct packed {
    logic [7:0] code;
    stack_arr_t arr;
    logic [4:0] flg;
  } row_t;

  // Code, stack arrangement, flags (S Z O C E)
  // float codes keep bit 6 clear
  // last rows: 16-bit stack and arithmetic codes and the idle command
  localparam row_t TBL [24] = '{
    '{8'h06, ARR_RUUU, 5'h19}, '{8'h07, ARR_RBUU, 5'h18}, '{8'h15, ARR_KEEP, 5'h18},
    '{8'h10, ARR_RCDU, 5'h19}, '{8'h11, ARR_RCDU, 5'h19}, '{8'h1c, ARR_RBCU, 5'h18},
    '{8'h18, ARR_ROTATE, 5'h18}, '{8'h17, ARR_DUP, 5'h18}, '{8'h19, ARR_SWAP, 5'h18},
    '{8'h1a, ARR_PUSH_RES, 5'h18}, '{8'h0b, ARR_RCUU, 5'h19}, '{8'h01, ARR_RBCU, 5'h19},
    '{8'h2c, ARR_RCDA, 5'h1b}, '{8'h2d, ARR_RCDA, 5'h1e}, '{8'h2e, ARR_RCDU, 5'h1c},
    '{8'h34, ARR_KEEP, 5'h1c}, '{8'h36, ARR_RCDU, 5'h1c}, '{8'h1e, ARR_RBCU, 5'h1c},
    '{8'h78, ARR_ROTATE, 5'h18}, '{8'h79, ARR_SWAP, 5'h18}, '{8'h6d, ARR_RCDA, 5'h1b},
    '{8'h6f, ARR_RCDU, 5'h19}, '{8'h74, ARR_KEEP, 5'h1c}, '{8'h00, ARR_KEEP, 5'h00}};

  logic         clk_sys = 1'h0;  // 10 MHz clock
  logic         arst_n  = 1'h0;  // Reset, active low
  logic         rd_en   = 1'h0;  // Bus read
  logic         wr_en   = 1'h0;  // Bus write
  logic         ack_en  = 1'h0;  // Host may acknowledge
  logic [3:0]   addr    = 4'h0;  // Word address
  logic [3:0]   be      = 4'hf;  // Byte lanes
  logic [3:0]   dly     = 4'h0;  // Host answer delay
  logic [31:0]  wdata   = 32'h0; // Write data
  logic [31:0]  rdata;           // Last read data
  logic [7:0]   c;               // Command under test
  fmt_t         f;               // Expected format
  logic         s;               // Request level before the command
  wire          ack_n;           // Acknowledge pin
  wire          svc;             // Service request pin
  wire          busy;            // Executing
  wire          wait_rq;         // Bus stall
  wire [31:0]   rdo;             // Bus read data
  decoded_cmd_t dec;             // Held decode
  int           error_cnt = 0;   // Mismatches
  int           n_checks  = 0;   // Comparisons
  int           n;               // Cycle count

  cmd_decoder cmd_decoder_inst (.clk_sys_in(clk_sys), .arst_n_in(arst_n),
    .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdo),
    .avs_waitrequest_out(wait_rq), .post_service_ack_n_in(ack_n),
    .post_service_request_out(svc), .busy_out(busy), .decoded_out(dec));

  svc_ack_model svc_ack_model_inst (.clk_sys_in(clk_sys), .arst_n_in(arst_n),
    .request_in(svc), .enable_in(ack_en), .delay_in(dly), .ack_n_out(ack_n));

  // Free-running clock, 100 ns period
  always #50 clk_sys = ~clk_sys;

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus cycle, held until waitrequest samples low, then one idle edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    addr  <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (wait_rq !== 1'h0 && k < 40);
    rdata = rdo;
    if (k >= 40)
      chk("waitrequest", wait_rq, 32'h0);
    wr_en <= 1'h0;
    rd_en <= 1'h0;
    @(posedge clk_sys);
  endtask

  // Verdict, the only place the run ends
  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog, far beyond the several hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'h1;
    @(posedge clk_sys);
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("status after reset", rdata, 32'h0);
    // Even rows ask for service, odd rows do not
    for (int i = 0; i < 24; i++)
    begin
      c = TBL[i].code | (i[0] ? 8'h00 : 8'h80);
      f = c[5] ? (c[6] ? FMT_SHORT : FMT_LONG) : FMT_FLOAT;
      s = svc;
      bus(1'h1, ADDR_CMD, {24'h0, c});
      bus(1'h1, ADDR_CMD, 32'h01);
      bus(1'h0, ADDR_STATUS, 32'h0);
      chk("status", rdata, {11'h0, TBL[i].flg, 4'h0, TBL[i].arr, 2'h0, f, 2'h1, s, 1'h1});
      chk("stack arrangement", dec.arr, TBL[i].arr);
      chk("flags long", rdata[20:16], TBL[i].flg);
      chk("format", rdata[5:4], f);
      chk("word16", dec.word16, f == FMT_SHORT);
      bus(1'h0, ADDR_CMD, 32'h0);
      chk("latched byte", rdata[7:0], c);
      chk("op", dec.op, c[4:0]);
      chk("svc bit", dec.svc, c[7]);
      bus(1'h1, ADDR_DONE, 32'h0);
      chk("busy and svc after done", {busy, svc}, {1'h0, c[7]});
    end
    bus(1'h0, 4'h5, 32'h0);
    chk("unmapped read", rdata, UNMAPPED_READ);
    // Lane 0 off: command must not start
    be <= 4'h0;
    bus(1'h1, ADDR_CMD, 32'h10);
    be <= 4'hf;
    chk("masked write", busy, 1'h0);
    bus(1'h1, ADDR_CMD, 32'h0c);
    chk("unknown code", {dec.legal, dec.arr, dec.flags}, {1'h0, ARR_NONE, 5'h0});
    bus(1'h1, ADDR_DONE, 32'h0);
    bus(1'h1, ADDR_DONE, 32'h0);
    chk("done while idle", {busy, svc}, 2'h0);
    // Pin acknowledge, prompt host then slow host
    for (int k = 0; k < 2; k++)
    begin
      bus(1'h1, ADDR_CMD, 32'h90);
      bus(1'h1, ADDR_DONE, 32'h0);
      chk("svc raised", svc, 1'h1);
      dly    <= 4'(k * 6);
      ack_en <= 1'h1;
      n = 0;
      while (svc === 1'h1 && n < 30)
      begin
        @(posedge clk_sys);
        n++;
      end
      chk("ack latency", n >= k * 6 + 1 && n <= k * 6 + 6, 1'h1);
      ack_en <= 1'h0;
      repeat (4) @(posedge clk_sys);
    end
    // Software acknowledge
    bus(1'h1, ADDR_CMD, 32'h81);
    bus(1'h1, ADDR_DONE, 32'h0);
    chk("svc before ack", svc, 1'h1);
    bus(1'h1, ADDR_ACK, 32'h1);
    chk("svc after ack", svc, 1'h0);
    stop_test();
  end
endmodule // cmd_decoder_tb_top
